/* src/ocs_map.svh */
// Register offsets, field layout, reset values and timing of the clock block.
`ifndef OCS_MAP_SVH
`define OCS_MAP_SVH

// =============================================================================
// Register word offsets (byte addresses)
`define OCS_CTRL_OFS      8'h00
`define OCS_TUNE_OFS      8'h04
`define OCS_CFG_OFS       8'h08

// =============================================================================
// Field positions and reset values
`define OCS_FSEL_LSB      0
`define OCS_LOCKED_BIT    2
`define OCS_STABLE_BIT    3
`define OCS_FSEL_RST      2'b10
`define OCS_TUNE_RST      6'h00

// =============================================================================
// Frequency select codes and clock source configuration codes
`define OCS_FSEL_DIV1     2'b11
`define OCS_FSEL_DIV2     2'b10
`define OCS_FSEL_DIV4     2'b01
`define OCS_FSEL_DIV8     2'b00
`define OCS_SRC_EXT_CODE  2'b00
`define OCS_SRC_FREE_CODE 2'b01

// =============================================================================
// Oscillator model: phase increments per 8 ns for 16 MHz and 500 kHz
`define OCS_INC_HF        32'h20C49BA6
`define OCS_INC_MF        32'h010624DD
`define OCS_TUNE_SHIFT    8

// =============================================================================
// Timing in ns and bus responses
`define OCS_CLK_NS        8
`define OCS_LOCK_NS       2000
`define OCS_STABLE_NS     8000
`define OCS_RESP_OKAY     2'b00
`define OCS_RESP_SLVERR   2'b10

`endif

/* src/ocs_pkg.sv */
// Types and shared decode functions of the oscillator clock select block.
package ocs_pkg;

`include "ocs_map.svh"

    typedef enum logic [1:0] {
        OCS_SRC_EXT,
        OCS_SRC_INT_CLOCK_OUTPUT_PIN,
        OCS_SRC_INT_FREE
    } ocs_src_t;

    typedef enum logic [1:0] {
        OCS_ST_WAIT_LOCK,
        OCS_ST_WAIT_STABLE,
        OCS_ST_SETTLED
    } ocs_settle_t;

    typedef struct packed {
        logic       mult_en;
        logic [1:0] source;
    } ocs_cfg_t;

    typedef struct packed {
        logic stable;
        logic locked;
    } ocs_status_t;

    function automatic ocs_src_t ocs_src_decode(input logic [1:0] code);
        if (code == `OCS_SRC_EXT_CODE) begin
            return OCS_SRC_EXT;
        end else if (code == `OCS_SRC_FREE_CODE) begin
            return OCS_SRC_INT_FREE;
        end
        return OCS_SRC_INT_CLOCK_OUTPUT_PIN;
    endfunction

    // Count mask of the postscaler: all ones fires the output tick.
    function automatic logic [2:0] ocs_div_mask(input logic [1:0] sel);
        case (sel)
            `OCS_FSEL_DIV1: return 3'h0;
            `OCS_FSEL_DIV2: return 3'h1;
            `OCS_FSEL_DIV4: return 3'h3;
            default:        return 3'h7;
        endcase
    endfunction

endpackage

/* src/ocs_postscaler.sv */
// Postscaler that passes every 1st, 2nd, 4th or 8th input tick.
`timescale 1ns/100ps
`default_nettype none

module ocs_postscaler
    import ocs_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_srst,
    // Tick in, ratio select, tick out
    input  wire logic       i_tick,
    input  wire logic [1:0] i_sel,
    output var  logic       o_tick
);

    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic [2:0] mask;
    logic       fire;

    // The ratio is read live, so a new select acts on the next tick.
    assign mask    = ocs_div_mask(i_sel);
    assign fire    = i_tick && ((cnt_r & mask) == mask);
    assign cnt_nxt = i_tick ? cnt_r + 3'h1 : cnt_r;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            cnt_r  <= 3'h0;
            o_tick <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            o_tick <= fire;
        end
    end

endmodule

`default_nettype wire

/* src/ocs_top.sv */
// Oscillator clock select block with AXI4-Lite control registers.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

`include "ocs_map.svh"

module ocs_top
    import ocs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_srst,
    // Programming-time configuration word
    input  wire ocs_cfg_t          i_config_word_one,
    // Clock input pin
    input  wire logic              i_clock_input_pin,
    // AXI4-Lite write address
    input  wire logic              i_awvalid,
    output var  logic              o_awready,
    input  wire logic [ADDR_W-1:0] i_awaddr,
    // AXI4-Lite write data
    input  wire logic              i_wvalid,
    output var  logic              o_wready,
    input  wire logic [31:0]       i_wdata,
    input  wire logic [3:0]        i_wstrb,
    // AXI4-Lite write response
    output var  logic              o_bvalid,
    input  wire logic              i_bready,
    output var  logic [1:0]        o_bresp,
    // AXI4-Lite read address
    input  wire logic              i_arvalid,
    output var  logic              o_arready,
    input  wire logic [ADDR_W-1:0] i_araddr,
    // AXI4-Lite read data
    output var  logic              o_rvalid,
    input  wire logic              i_rready,
    output var  logic [31:0]       o_rdata,
    output var  logic [1:0]        o_rresp,
    // System clock enable and pins
    output var  logic              o_sysclk_tick,
    output var  logic              o_clock_output_pin_pin,
    output var  logic              o_clock_output_pin_oe,
    output var  logic              o_clock_input_pin_gpio_en,
    output var  logic              o_clock_output_pin_gpio_en,
    // Oscillator status
    output var  ocs_status_t       o_status
);

    // =========================================================================
    // Constants
    localparam int LOCK_CYC =
        (`OCS_LOCK_NS + `OCS_CLK_NS - 1) / `OCS_CLK_NS;
    localparam int STABLE_CYC =
        (`OCS_STABLE_NS + `OCS_CLK_NS - 1) / `OCS_CLK_NS;
    localparam logic [15:0] LOCK_LAST   = 16'(LOCK_CYC - 1);
    localparam logic [15:0] STABLE_LAST = 16'(STABLE_CYC - 1);

    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [7:0]        ofs);
        return addr[ADDR_W-1:2] == ADDR_W'(ofs) >> 2;
    endfunction

    // Tuning is a signed trim in steps of 1/256 of the base increment.
    function automatic logic [31:0] tuned_inc(input logic [31:0] base,
                                              input logic [5:0]  tune);
        logic [31:0] ext;
        ext = {{26{tune[5]}}, tune};
        return base + ext * (base >> `OCS_TUNE_SHIFT);
    endfunction

    // =========================================================================
    // Configuration captured while reset is held
    ocs_cfg_t cfg_r;
    ocs_src_t src;
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            cfg_r <= i_config_word_one;
        end
    end

    assign src = ocs_src_decode(cfg_r.source);

    // =========================================================================
    // AXI4-Lite write channel
    logic              aw_hold_r;
    logic              w_hold_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              aw_take;
    logic              w_take;
    logic              wr_fire;
    logic              aw_hold_nxt;
    logic              w_hold_nxt;
    logic              bvalid_nxt;
    logic              wr_ctrl;
    logic              wr_tune;
    logic              wr_mapped;
    logic [1:0]        wr_fsel;
    assign aw_take     = i_awvalid && o_awready;
    assign w_take      = i_wvalid && o_wready;
    assign wr_fire     = aw_hold_r && w_hold_r && !o_bvalid;
    assign aw_hold_nxt = aw_take || (aw_hold_r && !wr_fire);
    assign w_hold_nxt  = w_take || (w_hold_r && !wr_fire);
    assign bvalid_nxt  = wr_fire || (o_bvalid && !i_bready);
    assign wr_ctrl     = wr_fire && wstrb_r[0]
                      && hit(aw_addr_r, `OCS_CTRL_OFS);
    assign wr_tune     = wr_fire && wstrb_r[0]
                      && hit(aw_addr_r, `OCS_TUNE_OFS);
    assign wr_mapped   = hit(aw_addr_r, `OCS_CTRL_OFS)
                      || hit(aw_addr_r, `OCS_TUNE_OFS)
                      || hit(aw_addr_r, `OCS_CFG_OFS);
    assign wr_fsel     = wdata_r[`OCS_FSEL_LSB +: 2];
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
            o_bvalid  <= 1'b0;
            o_bresp   <= `OCS_RESP_OKAY;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r  <= w_hold_nxt;
            o_awready <= !aw_hold_nxt;
            o_wready  <= !w_hold_nxt;
            o_bvalid  <= bvalid_nxt;
            if (wr_fire) begin
                o_bresp <= wr_mapped ? `OCS_RESP_OKAY : `OCS_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (aw_take) begin
            aw_addr_r <= i_awaddr;
        end
        if (w_take) begin
            wdata_r <= i_wdata;
            wstrb_r <= i_wstrb;
        end
    end

    // =========================================================================
    // Control and tuning registers
    logic [1:0] fsel_r;
    logic [5:0] tune_r;
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            fsel_r <= `OCS_FSEL_RST;
            tune_r <= `OCS_TUNE_RST;
        end else begin
            if (wr_ctrl) begin
                fsel_r <= wr_fsel;
            end
            if (wr_tune) begin
                tune_r <= wdata_r[5:0];
            end
        end
    end

    // =========================================================================
    // AXI4-Lite read channel
    logic        ar_take;
    logic        rvalid_nxt;
    logic [31:0] rd_word;
    logic        rd_mapped;
    assign ar_take    = i_arvalid && o_arready;
    assign rvalid_nxt = ar_take || (o_rvalid && !i_rready);
    assign rd_mapped  = hit(i_araddr, `OCS_CTRL_OFS)
                     || hit(i_araddr, `OCS_TUNE_OFS)
                     || hit(i_araddr, `OCS_CFG_OFS);
    assign rd_word    =
        hit(i_araddr, `OCS_CTRL_OFS) ? {28'h0000000, o_status, fsel_r} :
        hit(i_araddr, `OCS_TUNE_OFS) ? {26'h0000000, tune_r} :
        hit(i_araddr, `OCS_CFG_OFS)  ? {29'h00000000, cfg_r} :
                                       32'h00000000;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= `OCS_RESP_OKAY;
        end else begin
            o_arready <= !rvalid_nxt;
            o_rvalid  <= rvalid_nxt;
            if (ar_take) begin
                o_rdata <= rd_word;
                o_rresp <= rd_mapped ? `OCS_RESP_OKAY : `OCS_RESP_SLVERR;
            end
        end
    end

    // =========================================================================
    // Internal oscillator model
    // A phase accumulator stands in for the analog source; its carry is
    // one period of 16 MHz or 500 kHz, with 8 ns edge jitter.
    logic [31:0] acc_r;
    logic [31:0] inc_base;
    logic [31:0] inc;
    logic [32:0] acc_sum;
    logic        osc_tick_r;
    assign inc_base = cfg_r.mult_en ? `OCS_INC_HF : `OCS_INC_MF;
    assign inc      = tuned_inc(inc_base, tune_r);
    assign acc_sum  = {1'b0, acc_r} + {1'b0, inc};

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            acc_r      <= 32'h00000000;
            osc_tick_r <= 1'b0;
        end else begin
            acc_r      <= acc_sum[31:0];
            osc_tick_r <= acc_sum[32];
        end
    end

    // =========================================================================
    // Postscaler and clock-out divider
    logic sel_tick;
    logic half_tick;
    // Both frequency sets share one running source and one divider.
    ocs_postscaler u_post (
        .i_clock (i_clock),
        .i_srst  (i_srst),
        .i_tick  (osc_tick_r),
        .i_sel   (fsel_r),
        .o_tick  (sel_tick)
    );
    ocs_postscaler u_clock_output_pin_div (
        .i_clock (i_clock),
        .i_srst  (i_srst),
        .i_tick  (sel_tick),
        .i_sel   (`OCS_FSEL_DIV2),
        .o_tick  (half_tick)
    );

    // =========================================================================
    // System clock selection and pins
    logic pin_prev_r;
    logic sysclk_nxt;
    logic clock_output_pin_nxt;
    assign sysclk_nxt = (src == OCS_SRC_EXT)
                      ? (i_clock_input_pin && !pin_prev_r)
                      : sel_tick;
    // Toggling every second selected tick gives a quarter-rate square wave.
    assign clock_output_pin_nxt = (src == OCS_SRC_INT_CLOCK_OUTPUT_PIN)
                      ? (o_clock_output_pin_pin ^ half_tick)
                      : 1'b0;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            pin_prev_r       <= 1'b0;
            o_sysclk_tick    <= 1'b0;
            o_clock_output_pin_pin     <= 1'b0;
            o_clock_output_pin_oe      <= 1'b0;
            o_clock_input_pin_gpio_en  <= 1'b0;
            o_clock_output_pin_gpio_en <= 1'b0;
        end else begin
            pin_prev_r       <= i_clock_input_pin;
            o_sysclk_tick    <= sysclk_nxt;
            o_clock_output_pin_pin     <= clock_output_pin_nxt;
            o_clock_output_pin_oe      <= (src == OCS_SRC_INT_CLOCK_OUTPUT_PIN);
            o_clock_input_pin_gpio_en  <= (src != OCS_SRC_EXT);
            o_clock_output_pin_gpio_en <= (src != OCS_SRC_INT_CLOCK_OUTPUT_PIN);
        end
    end

    // =========================================================================
    // Settling status
    // A retune restarts settling, since the oscillator moves to a new value.
    ocs_settle_t state_r;
    logic [15:0] settle_cnt_r;
    always_ff @(posedge i_clock) begin
        if (i_srst || wr_tune) begin
            state_r      <= OCS_ST_WAIT_LOCK;
            settle_cnt_r <= 16'h0000;
            o_status     <= '0;
        end else begin
            case (state_r)
                OCS_ST_WAIT_LOCK: begin
                    settle_cnt_r <= settle_cnt_r + 16'h0001;
                    if (settle_cnt_r == LOCK_LAST) begin
                        o_status.locked <= 1'b1;
                        state_r         <= OCS_ST_WAIT_STABLE;
                    end
                end
                OCS_ST_WAIT_STABLE: begin
                    settle_cnt_r <= settle_cnt_r + 16'h0001;
                    if (settle_cnt_r == STABLE_LAST) begin
                        o_status.stable <= 1'b1;
                        state_r         <= OCS_ST_SETTLED;
                    end
                end
                default: begin
                    state_r <= OCS_ST_SETTLED;
                end
            endcase
        end
    end

    // =========================================================================
    // Assertions
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);
    fsel_reset_a:
        assert property ($fell(i_srst) |-> fsel_r == `OCS_FSEL_RST)
        else $error("Frequency select missed its reset code.");
    fsel_write_a:
        assert property (wr_ctrl |=> fsel_r == $past(wr_fsel))
        else $error("Frequency select write did not apply at once.");
    settle_order_a:
        assert property (o_status.stable |-> o_status.locked)
        else $error("Stable flag set without locked flag.");
    lock_time_a:
        assert property ($rose(o_status.locked)
            |-> settle_cnt_r == LOCK_LAST + 16'h0001)
        else $error("Locked flag at wrong settling count.");
    stable_time_a:
        assert property ($rose(o_status.stable)
            |-> settle_cnt_r == STABLE_LAST + 16'h0001)
        else $error("Stable flag at wrong settling count.");
    config_hold_a:
        assert property (1'b1 |=> $stable(cfg_r))
        else $error("Configuration changed outside reset.");
    // The release edge is left out: mode outputs settle one edge later.
    ext_clock_a:
        assert property (!i_srst && (src == OCS_SRC_EXT)
            && i_clock_input_pin && !pin_prev_r |=> o_sysclk_tick)
        else $error("External clock edge not passed to system clock.");
    int_div1_a:
        assert property ((src != OCS_SRC_EXT) && osc_tick_r
            && fsel_r == `OCS_FSEL_DIV1 |-> ##2 o_sysclk_tick)
        else $error("Divide by one dropped an oscillator tick.");
    inc_select_a:
        assert property (tune_r == `OCS_TUNE_RST |-> inc ==
            (cfg_r.mult_en ? `OCS_INC_HF : `OCS_INC_MF))
        else $error("Oscillator base does not follow multiplier bit.");
    clock_output_pin_free_a:
        assert property (!i_srst && (src != OCS_SRC_INT_CLOCK_OUTPUT_PIN)
            |=> !o_clock_output_pin_oe && !o_clock_output_pin_pin && o_clock_output_pin_gpio_en)
        else $error("Clock output pin driven outside clock-out mode.");
    clock_input_pin_free_a:
        assert property (!i_srst && (src != OCS_SRC_EXT)
            |=> o_clock_input_pin_gpio_en)
        else $error("Clock input pin not released in internal mode.");

endmodule

`default_nettype wire

/* testbench/ocs_ext_src_model.sv */
// Behavioural external clock source that drives the clock input pin.
`timescale 1ns/100ps
`default_nettype none

module ocs_ext_src_model (
    // Clock and run control
    input  wire logic       i_clock,
    input  wire logic       i_run,
    input  wire logic [7:0] i_half,
    // Clock input pin
    output var  logic       o_pin
);
    logic [7:0] cnt_r;

    // ====================
    // Square wave source
    // The pin rests low while stopped, so no stray edge reaches the block.
    always_ff @(posedge i_clock) begin
        if (!i_run) begin
            o_pin <= 1'b0;
            cnt_r <= 8'h00;
        end else if (cnt_r >= i_half - 8'h01) begin
            o_pin <= ~o_pin;
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* testbench/tb_internal_oscillator_clock_select.sv */
// Self-checking bench of the oscillator clock select block.
`timescale 1ns/100ps
`default_nettype none

`include "ocs_map.svh"

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_internal_oscillator_clock_select
    import ocs_pkg::*;
;
    localparam logic [1:0] OK = `OCS_RESP_OKAY;
    localparam logic [1:0] SE = `OCS_RESP_SLVERR;
    logic        clk, srst, awvalid, wvalid, bready, arvalid, rready, run;
    logic [7:0]  awaddr, araddr, half;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    ocs_cfg_t    cfg;
    logic        awready, wready, bvalid, arready, rvalid, tick, pin;
    logic        co_pin, co_oe, ci_gpio, co_gpio, co_prev;
    logic [1:0]  bresp, rresp, eb, code;
    logic [2:0]  pins;
    logic [5:0]  r;
    logic [33:0] er;
    ocs_status_t status;
    logic [1:0]  bq[$];
    logic [33:0] rq[$];
    int          err_total, n_checks, tick_cnt, co_cnt, i;

    assign pins = {co_oe, ci_gpio, co_gpio};
    always #4 clk = ~clk;

    ocs_top #(.ADDR_W(8)) dut (
        .i_clock(clk), .i_srst(srst), .i_config_word_one(cfg),
        .i_clock_input_pin(pin),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
        .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
        .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
        .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
        .o_rdata(rdata), .o_rresp(rresp), .o_sysclk_tick(tick),
        .o_clock_output_pin_pin(co_pin), .o_clock_output_pin_oe(co_oe),
        .o_clock_input_pin_gpio_en(ci_gpio), .o_clock_output_pin_gpio_en(co_gpio),
        .o_status(status)
    );

    ocs_ext_src_model src (
        .i_clock(clk), .i_run(run), .i_half(half), .o_pin(pin)
    );

    // ====================
    // Output watcher
    // Sampling mid-cycle keeps every handshake and tick seen exactly once.
    always @(negedge clk) begin
        if (tick === 1'b1) tick_cnt++;
        if (co_pin === 1'b1 && co_prev === 1'b0) co_cnt++;
        co_prev = co_pin;
        if (rvalid === 1'b1 && rready) begin
            er = rq.size() ? rq.pop_front() : 34'h3_FFFF_FFFF;
            `CHK({rresp, rdata}, er)
        end
        if (bvalid === 1'b1 && bready) begin
            eb = bq.size() ? bq.pop_front() : 2'h3;
            `CHK(bresp, eb)
        end
    end

    // ====================
    // Tasks
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s, input logic [1:0] e);
        int n;
        logic ta, tw, tb;
        bq.push_back(e);
        @(posedge clk);
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        awaddr <= a; wdata <= d; wstrb <= s;
        for (n = 0; n < 200; n++) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                break;
            end
        end
        if (n == 200) begin
            err_total++;
            report_and_stop();
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
        int n;
        logic ta, tr;
        rq.push_back(e);
        @(posedge clk);
        arvalid <= 1'b1; rready <= 1'b1; araddr <= a;
        for (n = 0; n < 200; n++) begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                break;
            end
        end
        if (n == 200) begin
            err_total++;
            report_and_stop();
        end
    endtask

    task automatic do_reset(input logic [2:0] c, input int cyc);
        @(posedge clk);
        srst <= 1'b1;
        cfg <= c;
        repeat (cyc) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    function automatic int snap(input int g, input int e);
        return (g >= e - 2 && g <= e + 2) ? e : g;
    endfunction

    // Counts ticks against n * num / den and clock-out rises against a quarter of it.
    task automatic measure(input int n, input int num, input int den,
                           input bit co);
        int t0, c0, et;
        t0 = tick_cnt;
        c0 = co_cnt;
        repeat (n) @(posedge clk);
        et = n * num / den;
        `CHK(snap(tick_cnt - t0, et), et)
        `CHK(snap(co_cnt - c0, co ? et / 4 : 0), co ? et / 4 : 0)
    endtask

    // ====================
    // Main sequence
    initial begin
        clk = 1'b0; srst = 1'b1; cfg = 3'b110; run = 1'b0; half = 8'h05;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; awaddr = 8'h00;
        arvalid = 1'b0; rready = 1'b0; araddr = 8'h00; wdata = 32'h0;
        wstrb = 4'h0; co_prev = 1'b0;
        err_total = 0; n_checks = 0; tick_cnt = 0; co_cnt = 0;
        void'($urandom(56505));
        do_reset(3'b110, 20);
        axi_rd(`OCS_CTRL_OFS, {OK, 32'h2});
        axi_rd(`OCS_CFG_OFS, {OK, 32'h6});
        axi_wr(`OCS_CFG_OFS, 32'h0, 4'hF, OK);
        axi_rd(`OCS_CFG_OFS, {OK, 32'h6});
        axi_rd(8'h0C, {SE, 32'h0});
        axi_wr(8'h10, 32'h1, 4'hF, SE);
        axi_wr(`OCS_CTRL_OFS, 32'h0, 4'h0, OK);
        axi_rd(`OCS_CTRL_OFS, {OK, 32'h2});
        repeat (300) @(posedge clk);
        axi_rd(`OCS_CTRL_OFS, {OK, 32'h6});
        repeat (800) @(posedge clk);
        axi_rd(`OCS_CTRL_OFS, {OK, 32'hE});
        `CHK(pins, 3'b110)
        // The pin toggles here too: internal modes must ignore it.
        half <= 8'h03;
        run <= 1'b1;
        for (i = 0; i < 4; i++) begin
            code = 2'(3 - i);
            axi_wr(`OCS_CTRL_OFS, {28'h0, 2'b11, code}, 4'h1, OK);
            axi_rd(`OCS_CTRL_OFS, {OK, 28'h0, 2'b11, code});
            measure(2048, 128, 1000 << i, 1'b1);
        end
        r = 6'($urandom);
        axi_wr(`OCS_CTRL_OFS, 32'h3, 4'hF, OK);
        axi_wr(`OCS_TUNE_OFS, {26'h0, r}, 4'hF, OK);
        axi_rd(`OCS_TUNE_OFS, {OK, 26'h0, r});
        axi_rd(`OCS_CTRL_OFS, {OK, 32'h3});
        measure(4096, 128 * (256 + int'($signed(r))), 256000, 1'b1);
        do_reset(3'b001, 2);
        `CHK(pins, 3'b011)
        for (i = 0; i < 4; i++) begin
            code = 2'(3 - i);
            axi_wr(`OCS_CTRL_OFS, {30'h0, code}, 4'h1, OK);
            measure(8000, 1, 250 << i, 1'b0);
        end
        axi_wr(`OCS_CTRL_OFS, 32'h3, 4'hF, OK);
        axi_wr(`OCS_TUNE_OFS, {26'h0, ~r}, 4'hF, OK);
        measure(8000, 256 + int'($signed(~r)), 64000, 1'b0);
        do_reset(3'b000, 2);
        `CHK(pins, 3'b001)
        half <= 8'h05;
        measure(2000, 1, 10, 1'b0);
        half <= 8'h0C;
        measure(2400, 1, 24, 1'b0);
        report_and_stop();
    end
endmodule
`default_nettype wire
